// file: src/ipl_defs.svh
// Shared constants for the identification-page lock slice of the serial EEPROM.
// Assumes a 100 MHz system clock and an SPI mode 0 link driven by the host end.
// How it works
// - Host selects, sends opcode and address MSB first
// - Lock query sets page-select bit, rest zero
// - Status byte LSB shows page locked
// - Same status byte repeats while selected
// - Deselect ends read, output released
// - Lock query refused during write cycle
// - Lock frame: opcode, address, one data byte
// - Lock address sets page-select bit
// - Lock data byte needs bit one set
// - Deselect off byte boundary drops lock
// - Valid lock starts timed write cycle
// - Executed lock is permanent and irreversible
// - Lock refused: busy, full protect, no enable
// - Instructions ignored while power-on reset active
// - Reset leaves standby, clears enable and busy
// - Reset keeps nonvolatile protect bits unchanged
// - Supply-low reset stops device operation
// - Single bit error corrected per byte
// - Delivered blank, page starts with ident code
// - Delivered with protect bits all zero
// - Only selected device drives data out
// - Page access sends page-select bit zero
`ifndef IPL_DEFS_SVH
`define IPL_DEFS_SVH

// Opcodes, plain defaults
`define IPL_OP_READ_IDENT  8'h83
`define IPL_OP_WRITE_IDENT 8'h82
`define IPL_OP_WREN        8'h06
`define IPL_OP_WRDI        8'h04

// Frame layout
`define IPL_PAGE_SEL_BIT   10
`define IPL_LOCK_DATA_BIT  1
`define IPL_ADDR_BYTES     6'h03
`define IPL_LOCK_BYTES     6'h04
`define IPL_BYTE_CNT_MAX   6'h3f

// Identification page and delivery contents (code bytes are arbitrary)
`define IPL_ID_BYTES       32
`define IPL_ID_CODE0       8'h5a
`define IPL_ID_CODE1       8'h11
`define IPL_ID_CODE2       8'h22
`define IPL_BLANK_BYTE     8'hff
`define IPL_BUS_IDLE_LEVEL 1'b1

// Timing
`define IPL_CLK_PERIOD_NS    10
`define IPL_WRITE_CYCLE_NS   5000000
`define IPL_WRITE_CYCLE_CYCLES \
	((`IPL_WRITE_CYCLE_NS + `IPL_CLK_PERIOD_NS - 1) / `IPL_CLK_PERIOD_NS)
`define IPL_DESELECT_CYCLES  4'h8

`endif

// file: src/ipl_pkg.sv
// Types for both ends of the link and ECC helpers for the EEPROM end.
// Assumes ipl_defs.svh is on the include path.
`include "ipl_defs.svh"

package ipl_pkg;

	// Host-side command kinds
	typedef enum logic [2:0] {
		IPL_CMD_LOCK_QUERY = 3'b000,
		IPL_CMD_LOCK       = 3'b001,
		IPL_CMD_WREN       = 3'b010,
		IPL_CMD_WRDI       = 3'b011,
		IPL_CMD_ID_READ    = 3'b100,
		IPL_CMD_ID_WRITE   = 3'b101
	} ipl_cmd_e;

	// Host frame sequencer
	typedef enum logic [1:0] {
		IPL_HS_IDLE  = 2'b00,
		IPL_HS_SHIFT = 2'b01,
		IPL_HS_GAP   = 2'b10
	} ipl_hstate_e;

	// Nonvolatile status bits
	typedef struct packed {
		logic statusWriteDisable;
		logic blockProtectHi;
		logic blockProtectLo;
	} ipl_nvstat_s;

	// Stored byte with four Hamming check bits
	typedef logic [11:0] ipl_code_t;

	// Data at codeword positions 3,5,6,7,9..12, parity at 1,2,4,8
	function automatic ipl_code_t eccEncode(input logic [7:0] d);
		ipl_code_t c;
		int        k;
		int        i;
		c = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00};
		for (k = 0; k < 4; k++) begin
			for (i = 1; i <= 12; i++) begin
				if (i[k] && (i != (1 << k))) begin
					c[(1 << k) - 1] = c[(1 << k) - 1] ^ c[i - 1];
				end
			end
		end
		return c;
	endfunction

	// Syndrome points at the flipped position, zero when clean
	function automatic logic [7:0] eccDecode(input ipl_code_t cw);
		ipl_code_t  c;
		logic [3:0] syn;
		int         i;
		c = cw;
		syn = 4'h0;
		for (i = 1; i <= 12; i++) begin
			if (c[i - 1]) begin
				syn = syn ^ i[3:0];
			end
		end
		if (syn != 4'h0 && syn <= 4'hc) begin
			c[syn - 4'h1] = ~c[syn - 4'h1];
		end
		return {c[11:8], c[6:4], c[2]};
	endfunction

endpackage

// file: src/ipl_spi_if.sv
// SPI link between host and EEPROM ends.
// Assumes a pull-up on the data-out line; no high impedance inside the design.
`timescale 1ns/1ps
`include "ipl_defs.svh"

interface ipl_spi_if;
	logic csN;
	logic sck;
	logic mosi;
	logic miso;
	logic misoOe;
	logic misoLine;

	// Pull-up stands in for the released line
	assign misoLine = misoOe ? miso : `IPL_BUS_IDLE_LEVEL;

	modport device (input csN, input sck, input mosi, output miso, output misoOe);
	modport host   (output csN, output sck, output mosi, input misoLine);
endinterface

// file: src/ipl_device.sv
// EEPROM end: identification page, lock bit and timed write cycle.
// Assumes the link clock stops outside frames and the host leaves several
// system clocks between deselect and the next first clock edge.
`timescale 1ns/1ps
`include "ipl_defs.svh"

module ipl_device #(
	parameter int unsigned WRITE_CYCLE_CYCLES = `IPL_WRITE_CYCLE_CYCLES
) (
	// System clock and power-on reset
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// Factory and status preset
	input  wire logic                 factoryLoad,
	input  wire logic                 nvStatusLoad,
	input  wire ipl_pkg::ipl_nvstat_s nvStatusIn,
	// Link
	ipl_spi_if.device                 spi,
	// State view
	output logic                      identLocked,
	output logic                      writeBusy,
	output logic                      writeEnabled
);
	import ipl_pkg::*;

	// Link-side capture
	logic [2:0]  bitCnt;
	logic [5:0]  byteCnt;
	logic [7:0]  shiftIn;
	logic [7:0]  nextShift;
	logic [7:0]  opcode;
	logic        pageSel;
	logic [4:0]  offset;
	logic [7:0]  dataByte;
	logic [2:0]  endBits;
	logic [5:0]  endBytes;
	logic        frameTag;
	logic [6:0]  outShift;
	logic [4:0]  rdPtr;
	logic [7:0]  loadByte;
	logic        readOk;
	// System-side state
	logic        csMeta;
	logic        csSync;
	logic        csPrev;
	logic        tagMeta;
	logic        tagSync;
	logic        lastTag;
	logic        frameOk;
	logic        busyHold;
	logic        lockHold;
	logic        readyHold;
	ipl_nvstat_s nvStat;
	ipl_code_t   idMem [`IPL_ID_BYTES];
	logic [31:0] wcCnt;
	logic        pendLock;
	logic [4:0]  pendOff;
	logic [7:0]  pendData;
	logic        frameEnd;
	logic        exec;
	logic        onBoundary;
	logic        doWren;
	logic        doWrdi;
	logic        doLock;
	logic        doIdWrite;
	logic        commitNow;

	assign nextShift = {shiftIn[6:0], spi.mosi};

	// Bit and byte position, cleared whenever the host deselects
	always_ff @(posedge spi.sck or posedge spi.csN) begin
		if (spi.csN) begin
			bitCnt  <= 3'h0;
			byteCnt <= 6'h00;
		end else begin
			bitCnt <= bitCnt + 3'h1;
			if (bitCnt == 3'h7 && byteCnt != `IPL_BYTE_CNT_MAX) begin
				byteCnt <= byteCnt + 6'h01;
			end
		end
	end

	// Field capture; kept across deselect so the system side can read it
	always_ff @(posedge spi.sck or posedge sys_rst) begin
		if (sys_rst) begin
			shiftIn  <= 8'h00;
			opcode   <= 8'h00;
			pageSel  <= 1'b0;
			offset   <= 5'h00;
			dataByte <= 8'h00;
			endBits  <= 3'h0;
			endBytes <= 6'h00;
			frameTag <= 1'b0;
		end else begin
			shiftIn <= nextShift;
			if (bitCnt == 3'h0 && byteCnt == 6'h00) begin
				frameTag <= ~frameTag; // Marks a frame that saw clocks
			end
			if (bitCnt == 3'h7) begin
				case (byteCnt)
					6'h00: begin
						opcode <= nextShift;
					end
					6'h01: begin
						pageSel <= nextShift[`IPL_PAGE_SEL_BIT - 8];
					end
					6'h02: begin
						offset <= nextShift[4:0];
					end
					6'h03: begin
						dataByte <= nextShift;
					end
					default: begin
					end
				endcase
			end
			endBits <= bitCnt + 3'h1;
			if (bitCnt == 3'h7 && byteCnt != `IPL_BYTE_CNT_MAX) begin
				endBytes <= byteCnt + 6'h01;
			end else begin
				endBytes <= byteCnt;
			end
		end
	end

	// Reads need the read opcode, power-up done and no write running
	assign readOk = (opcode == `IPL_OP_READ_IDENT) && readyHold && !busyHold;
	assign loadByte = pageSel ? {7'h00, lockHold} :
		eccDecode(idMem[(byteCnt == `IPL_ADDR_BYTES) ? offset : rdPtr]);

	// Data out on falling edges; released at once on deselect
	always_ff @(negedge spi.sck or posedge spi.csN) begin
		if (spi.csN) begin
			spi.miso   <= `IPL_BUS_IDLE_LEVEL;
			spi.misoOe <= 1'b0;
			outShift   <= 7'h00;
			rdPtr      <= 5'h00;
		end else if (bitCnt == 3'h0 && byteCnt >= `IPL_ADDR_BYTES) begin
			spi.miso   <= loadByte[7];
			spi.misoOe <= readOk;
			outShift   <= loadByte[6:0];
			if (byteCnt == `IPL_ADDR_BYTES) begin
				rdPtr <= offset + 5'h01;
			end else begin
				rdPtr <= rdPtr + 5'h01;
			end
		end else begin
			spi.miso <= outShift[6];
			outShift <= {outShift[5:0], 1'b0};
		end
	end

	// Select line and frame tag into the system domain
	always_ff @(posedge clk) begin
		csMeta  <= spi.csN;
		csSync  <= csMeta;
		csPrev  <= csSync;
		tagMeta <= frameTag;
		tagSync <= tagMeta;
	end

	// Frame admitted only if it began and ended outside reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frameOk <= 1'b0;
			lastTag <= 1'b0;
		end else begin
			if (csPrev && !csSync) begin
				frameOk <= 1'b1;
			end
			if (frameEnd) begin
				lastTag <= tagSync;
			end
		end
	end

	// Snapshots seen by the link side; frozen while selected so they are quasi-static
	always_ff @(posedge clk) begin
		if (csSync || sys_rst) begin
			busyHold  <= writeBusy;
			lockHold  <= identLocked;
			readyHold <= !sys_rst;
		end
	end

	// Decode at deselect; capture registers are stable once the clock has stopped
	assign frameEnd   = !csPrev && csSync;
	assign exec       = frameEnd && frameOk && !sys_rst && (tagSync != lastTag) && !writeBusy;
	assign onBoundary = (endBits == 3'h0) && (endBytes >= `IPL_LOCK_BYTES);
	assign doWren     = exec && opcode == `IPL_OP_WREN && endBytes == 6'h01 && endBits == 3'h0;
	assign doWrdi     = exec && opcode == `IPL_OP_WRDI && endBytes == 6'h01 && endBits == 3'h0;
	assign doLock     = exec && opcode == `IPL_OP_WRITE_IDENT && pageSel && onBoundary &&
		dataByte[`IPL_LOCK_DATA_BIT] && writeEnabled &&
		!(nvStat.blockProtectHi && nvStat.blockProtectLo);
	assign doIdWrite  = exec && opcode == `IPL_OP_WRITE_IDENT && !pageSel && onBoundary &&
		writeEnabled && !identLocked &&
		!(nvStat.blockProtectHi && nvStat.blockProtectLo);
	assign commitNow  = writeBusy && (wcCnt == 32'h0);

	// Self-timed write cycle; reset aborts it without committing
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			writeBusy <= 1'b0;
			wcCnt     <= 32'h0;
			pendLock  <= 1'b0;
			pendOff   <= 5'h00;
			pendData  <= 8'h00;
		end else if (doLock || doIdWrite) begin
			writeBusy <= 1'b1;
			wcCnt     <= WRITE_CYCLE_CYCLES - 32'h1;
			pendLock  <= doLock;
			pendOff   <= offset;
			pendData  <= dataByte;
		end else if (commitNow) begin
			writeBusy <= 1'b0;
		end else if (writeBusy) begin
			wcCnt <= wcCnt - 32'h1;
		end
	end

	// Write enable latch
	always_ff @(posedge clk) begin
		if (sys_rst || doWrdi || commitNow) begin
			writeEnabled <= 1'b0;
		end else if (doWren) begin
			writeEnabled <= 1'b1;
		end
	end

	// Lock bit: nonvolatile, only factory load clears it
	always_ff @(posedge clk) begin
		if (factoryLoad) begin
			identLocked <= 1'b0;
		end else if (commitNow && pendLock && !sys_rst) begin
			identLocked <= 1'b1;
		end
	end

	// Protect bits untouched by reset; preset port stands in for the status write
	always_ff @(posedge clk) begin
		if (factoryLoad) begin
			nvStat <= '0;
		end else if (nvStatusLoad) begin
			nvStat <= nvStatusIn;
		end
	end

	// Identification page storage, ECC-coded per byte
	always_ff @(posedge clk) begin
		if (factoryLoad) begin
			for (int i = 0; i < `IPL_ID_BYTES; i++) begin
				idMem[i] <= eccEncode(`IPL_BLANK_BYTE);
			end
			idMem[0] <= eccEncode(`IPL_ID_CODE0);
			idMem[1] <= eccEncode(`IPL_ID_CODE1);
			idMem[2] <= eccEncode(`IPL_ID_CODE2);
		end else if (commitNow && !pendLock && !sys_rst) begin
			idMem[pendOff] <= eccEncode(pendData);
		end
	end
endmodule

// file: src/ipl_host.sv
// Host end: turns user commands into SPI mode 0 frames.
// Assumes the device samples on rising and drives on falling link clock edges.
`timescale 1ns/1ps
`include "ipl_defs.svh"

module ipl_host (
	// System clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Command
	input  wire logic              cmdValid,
	input  wire ipl_pkg::ipl_cmd_e cmdKind,
	input  wire logic [4:0]        cmdOffset,
	input  wire logic [7:0]        cmdData,
	output logic                   cmdReady,
	// Response
	output logic                   rspValid,
	output logic [7:0]             rspData,
	// Link
	ipl_spi_if.host                spi
);
	import ipl_pkg::*;

	ipl_hstate_e state;
	logic [31:0] txShift;
	logic [5:0]  bitsLeft;
	logic [2:0]  divCnt;
	logic [3:0]  gapCnt;
	logic [7:0]  rxShift;
	logic        isRead;
	logic        misoMeta;
	logic        misoSync;
	logic [15:0] addrWord;
	logic [31:0] frame;

	// Page-select bit high for lock query and lock, low for page access
	assign addrWord = (cmdKind == IPL_CMD_LOCK_QUERY || cmdKind == IPL_CMD_LOCK) ?
		16'h0400 : {11'h000, cmdOffset};
	always_comb begin
		case (cmdKind)
			IPL_CMD_LOCK_QUERY, IPL_CMD_ID_READ: begin
				frame = {`IPL_OP_READ_IDENT, addrWord, 8'h00};
			end
			IPL_CMD_LOCK, IPL_CMD_ID_WRITE: begin
				frame = {`IPL_OP_WRITE_IDENT, addrWord, cmdData};
			end
			IPL_CMD_WREN: begin
				frame = {`IPL_OP_WREN, 24'h000000};
			end
			default: begin
				frame = {`IPL_OP_WRDI, 24'h000000};
			end
		endcase
	end

	// Data-in line comes from the other party
	always_ff @(posedge clk) begin
		misoMeta <= spi.misoLine;
		misoSync <= misoMeta;
	end

	// Frame sequencer; link clock is clk divided by eight
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state    <= IPL_HS_IDLE;
			spi.csN  <= 1'b1;
			spi.sck  <= 1'b0;
			spi.mosi <= 1'b0;
			cmdReady <= 1'b0;
			rspValid <= 1'b0;
			rspData  <= 8'h00;
			txShift  <= 32'h0;
			bitsLeft <= 6'h00;
			divCnt   <= 3'h0;
			gapCnt   <= 4'h0;
			rxShift  <= 8'h00;
			isRead   <= 1'b0;
		end else begin
			rspValid <= 1'b0;
			case (state)
				IPL_HS_IDLE: begin
					cmdReady <= 1'b1;
					if (cmdValid && cmdReady) begin
						cmdReady <= 1'b0;
						spi.csN  <= 1'b0;
						spi.mosi <= frame[31];
						txShift  <= {frame[30:0], 1'b0};
						bitsLeft <= (cmdKind == IPL_CMD_WREN || cmdKind == IPL_CMD_WRDI) ?
							6'h08 : 6'h20;
						isRead   <= (cmdKind == IPL_CMD_LOCK_QUERY || cmdKind == IPL_CMD_ID_READ);
						divCnt   <= 3'h0;
						state    <= IPL_HS_SHIFT;
					end
				end
				IPL_HS_SHIFT: begin
					divCnt <= divCnt + 3'h1;
					if (divCnt == 3'h3) begin
						spi.sck <= 1'b1;
					end else if (divCnt == 3'h7) begin
						spi.sck  <= 1'b0;
						rxShift  <= {rxShift[6:0], misoSync};
						bitsLeft <= bitsLeft - 6'h01;
						if (bitsLeft == 6'h01) begin
							spi.csN <= 1'b1; // on a byte boundary
							gapCnt  <= `IPL_DESELECT_CYCLES;
							state   <= IPL_HS_GAP;
						end else begin
							spi.mosi <= txShift[31];
							txShift  <= {txShift[30:0], 1'b0};
						end
					end
				end
				IPL_HS_GAP: begin
					// Gap lets the device see deselect before the next frame
					gapCnt <= gapCnt - 4'h1;
					if (gapCnt == 4'h1) begin
						rspValid <= isRead;
						rspData  <= rxShift;
						cmdReady <= 1'b1;
						state    <= IPL_HS_IDLE;
					end
				end
				default: begin
					state <= IPL_HS_IDLE;
				end
			endcase
		end
	end
endmodule

// file: test/ipl_link_asserts.sv
// Protocol checks on the host to device link.
// Assumes link signals are sampled on the system clock that makes the link clock.
`timescale 1ns/1ps

module ipl_link_asserts (
	// System clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Link
	input wire logic csN,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic misoOe
);
	logic       sckQ;
	logic [7:0] riseCnt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// Link clock rises within one frame, cleared while deselected
	always_ff @(posedge clk) begin
		sckQ <= sck;
		if (sys_rst || csN) begin
			riseCnt <= 8'h00;
		end else if (sck && !sckQ && riseCnt != 8'hff) begin
			riseCnt <= riseCnt + 8'h01;
		end
	end

	property p_releaseOnDeselect;
		csN |-> !misoOe;
	endproperty
	a_releaseOnDeselect: assert property (p_releaseOnDeselect)
		else $error("data out driven while deselected");

	property p_sckIdle;
		csN |-> !sck;
	endproperty
	a_sckIdle: assert property (p_sckIdle)
		else $error("link clock active outside a frame");

	property p_sckHigh;
		$rose(sck) |-> sck [*4] ##1 !sck;
	endproperty
	a_sckHigh: assert property (p_sckHigh)
		else $error("link clock high phase not four cycles");

	property p_sckLow;
		$fell(sck) && !csN |-> !sck [*4] ##1 sck;
	endproperty
	a_sckLow: assert property (p_sckLow)
		else $error("link clock low phase not four cycles");

	property p_mosiStable;
		sck |-> $stable(mosi);
	endproperty
	a_mosiStable: assert property (p_mosiStable)
		else $error("data in moved while link clock high");

	property p_deselectGap;
		$rose(csN) |-> csN [*8];
	endproperty
	a_deselectGap: assert property (p_deselectGap)
		else $error("deselect gap shorter than eight cycles");

	property p_driveAfterHeader;
		$rose(misoOe) |-> riseCnt == 8'h18 && !csN;
	endproperty
	a_driveAfterHeader: assert property (p_driveAfterHeader)
		else $error("data out started off the header end");

	property p_misoStable;
		misoOe && sck |-> $stable(miso);
	endproperty
	a_misoStable: assert property (p_misoStable)
		else $error("data out moved while link clock high");

	// Main traffic seen
	c_readDriven: cover property ($rose(misoOe));
	c_frameEnd: cover property ($rose(csN));
	c_longDrive: cover property (misoOe [*8]);
endmodule

// file: test/tb_id_page_lock_and_power_on_state.sv
// Self-checking bench: host end against one device, plus a bit-banged second device.
// Assumes the design files and ipl_defs.svh are on the include path.
`timescale 1ns/1ps
`include "ipl_defs.svh"
`define CHK(nm, exp, got) \
	begin \
		checks++; \
		if ((got) !== (exp)) begin \
			errorCnt++; \
			$display("mismatch %s exp %h got %h", nm, (exp), (got)); \
		end \
	end

module tb_id_page_lock_and_power_on_state;
	import ipl_pkg::*;
	localparam int WCYC = 1000;

	logic        clk;
	logic        sys_rst;
	logic        factoryLoad;
	logic        nvStatusLoad;
	ipl_nvstat_s nvStatusIn;
	logic        cmdValid;
	ipl_cmd_e    cmdKind;
	logic [4:0]  cmdOffset;
	logic [7:0]  cmdData;
	logic        cmdReady;
	logic        rspValid;
	logic [7:0]  rspData;
	logic        identLocked;
	logic        writeBusy;
	logic        writeEnabled;
	logic        locked2;
	logic        busy2;
	logic        enabled2;
	logic [7:0]  expQ[$];
	logic [7:0]  expNow;
	logic [7:0]  randByte;
	logic [47:0] rx;
	logic [7:0]  idExp[4];
	int          errorCnt;
	int          checks;
	integer      seed;

	ipl_spi_if spi ();
	ipl_spi_if spi2 ();

	ipl_host u_ipl_host (.clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdKind(cmdKind),
		.cmdOffset(cmdOffset), .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
		.rspData(rspData), .spi(spi.host));
	ipl_device #(.WRITE_CYCLE_CYCLES(WCYC)) u_ipl_device (.clk(clk), .sys_rst(sys_rst),
		.factoryLoad(factoryLoad), .nvStatusLoad(nvStatusLoad), .nvStatusIn(nvStatusIn),
		.spi(spi.device), .identLocked(identLocked), .writeBusy(writeBusy),
		.writeEnabled(writeEnabled));
	// Second device faces the bench, which breaks framing on purpose
	ipl_device #(.WRITE_CYCLE_CYCLES(WCYC)) u_ipl_device_b (.clk(clk), .sys_rst(sys_rst),
		.factoryLoad(factoryLoad), .nvStatusLoad(nvStatusLoad), .nvStatusIn(nvStatusIn),
		.spi(spi2.device), .identLocked(locked2), .writeBusy(busy2), .writeEnabled(enabled2));
	ipl_link_asserts u_ipl_link_asserts (.clk(clk), .sys_rst(sys_rst), .csN(spi.csN),
		.sck(spi.sck), .mosi(spi.mosi), .miso(spi.miso), .misoOe(spi.misoOe));

	// System clock
	always #(`IPL_CLK_PERIOD_NS / 2) clk = ~clk;

	task automatic wrap_up();
		if (errorCnt == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic logic pick(input int w);
		return (w == 0) ? cmdReady : (w == 1) ? writeBusy : busy2;
	endfunction

	// Bounded wait at the falling edge, so registered levels have settled
	task automatic waitLvl(input int w, input logic lvl, input int lim);
		int n;
		n = 0;
		while (pick(w) !== lvl) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				`CHK("wait", lim, n)
				wrap_up();
			end
		end
	endtask

	// One host command; returns once the host is idle again
	task automatic doCmd(input ipl_cmd_e k, input logic [4:0] o, input logic [7:0] d);
		waitLvl(0, 1'b1, 400);
		@(posedge clk);
		cmdValid  <= 1'b1;
		cmdKind   <= k;
		cmdOffset <= o;
		cmdData   <= d;
		@(posedge clk);
		cmdValid <= 1'b0;
		repeat (2) @(negedge clk);
		waitLvl(0, 1'b1, 400);
	endtask

	task automatic setProt(input logic [1:0] bp);
		@(posedge clk);
		nvStatusLoad <= 1'b1;
		nvStatusIn   <= '{1'b0, bp[1], bp[0]};
		@(posedge clk);
		nvStatusLoad <= 1'b0;
	endtask

	// Mode 0 frame of n bits on the second link, MSB first; may stop mid-byte
	task automatic bang(input logic [47:0] v, input int n, output logic [47:0] r);
		int i;
		r = '0;
		for (i = n - 1; i >= 0; i--) begin
			@(posedge clk);
			spi2.csN  <= 1'b0;
			spi2.mosi <= v[i];
			repeat (4) @(posedge clk);
			spi2.sck <= 1'b1;
			repeat (4) @(posedge clk);
			r = {r[46:0], spi2.misoLine};
			spi2.sck <= 1'b0;
		end
		spi2.csN <= 1'b1;
		repeat (12) @(posedge clk);
	endtask

	// Each read answer against the oldest note
	always @(posedge clk) begin
		if (rspValid === 1'b1) begin
			expNow = expQ.pop_front();
			`CHK("rspData", expNow, rspData)
		end
	end

	initial begin
		clk = 1'b0;
		// Processes start before reset rises, so every reset edge is seen
		#1;
		sys_rst = 1'b1;
		factoryLoad = 1'b1;
		nvStatusLoad = 1'b0;
		nvStatusIn = '0;
		cmdValid = 1'b0;
		cmdKind = IPL_CMD_LOCK_QUERY;
		cmdOffset = 5'h00;
		cmdData = 8'h00;
		spi2.csN = 1'b1;
		spi2.sck = 1'b0;
		spi2.mosi = 1'b0;
		errorCnt = 0;
		checks = 0;
		seed = 32'h31d9cbe8;
		idExp = '{`IPL_ID_CODE0, `IPL_ID_CODE1, `IPL_ID_CODE2, `IPL_BLANK_BYTE};
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		factoryLoad <= 1'b0;
		// Single flipped bit in any codeword position is repaired
		for (int j = 0; j < 12; j++) begin
			randByte = 8'($random(seed));
			`CHK("eccFix", randByte, eccDecode(eccEncode(randByte) ^ (12'h001 << j)))
		end
		expQ.push_back(8'h00);
		doCmd(IPL_CMD_LOCK_QUERY, 5'($random(seed)), 8'h00);
		for (int i = 0; i < 4; i++) begin
			expQ.push_back(idExp[i]);
			doCmd(IPL_CMD_ID_READ, (i == 3) ? 5'h07 : 5'(i), 8'h00);
		end
		// Page write while unlocked, then read back
		doCmd(IPL_CMD_WREN, 5'h00, 8'h00);
		randByte = 8'($random(seed));
		doCmd(IPL_CMD_ID_WRITE, 5'h05, randByte);
		`CHK("busyIdWriteOpen", 1'b1, writeBusy)
		waitLvl(1, 1'b0, 1200);
		expQ.push_back(randByte);
		doCmd(IPL_CMD_ID_READ, 5'h05, 8'h00);
		// Refusals: no enable after a disable, full protect, bad data pattern
		doCmd(IPL_CMD_WREN, 5'h00, 8'h00);
		doCmd(IPL_CMD_WRDI, 5'h00, 8'h00);
		`CHK("disable", 1'b0, writeEnabled)
		doCmd(IPL_CMD_LOCK, 5'h00, 8'h02);
		`CHK("busyNoEnable", 1'b0, writeBusy)
		setProt(2'b11);
		doCmd(IPL_CMD_WREN, 5'h00, 8'h00);
		`CHK("enable", 1'b1, writeEnabled)
		doCmd(IPL_CMD_LOCK, 5'h00, 8'h02);
		`CHK("busyProtect", 1'b0, writeBusy)
		setProt(2'b00);
		doCmd(IPL_CMD_LOCK, 5'h00, 8'($random(seed)) & 8'hfd);
		`CHK("busyPattern", 1'b0, writeBusy)
		doCmd(IPL_CMD_WREN, 5'h00, 8'h00);
		doCmd(IPL_CMD_LOCK, 5'h00, 8'($random(seed)) | 8'h02);
		`CHK("busyLock", 1'b1, writeBusy)
		expQ.push_back(8'hff);
		doCmd(IPL_CMD_LOCK_QUERY, 5'h00, 8'h00);
		waitLvl(1, 1'b0, 1200);
		`CHK("locked", 1'b1, identLocked)
		`CHK("enableDone", 1'b0, writeEnabled)
		doCmd(IPL_CMD_WREN, 5'h00, 8'h00);
		doCmd(IPL_CMD_ID_WRITE, 5'h03, 8'h33);
		`CHK("busyIdWrite", 1'b0, writeBusy)
		expQ.push_back(8'hff);
		doCmd(IPL_CMD_ID_READ, 5'h03, 8'h00);
		expQ.push_back(8'h01);
		doCmd(IPL_CMD_LOCK_QUERY, 5'h00, 8'h00);
		// Mid-run reset with a frame sent to the second device meanwhile
		doCmd(IPL_CMD_WREN, 5'h00, 8'h00);
		setProt(2'b11);
		sys_rst <= 1'b1;
		// Reset lifts mid-frame: a frame begun in reset must not run
		fork
			bang(48'(`IPL_OP_WREN), 8, rx);
			begin
				repeat (20) @(posedge clk);
				sys_rst <= 1'b0;
			end
		join
		repeat (4) @(negedge clk);
		`CHK("enableAfterReset", 1'b0, writeEnabled)
		`CHK("busyAfterReset", 1'b0, writeBusy)
		`CHK("lockAfterReset", 1'b1, identLocked)
		`CHK("enableInReset", 1'b0, enabled2)
		expQ.push_back(8'h01);
		doCmd(IPL_CMD_LOCK_QUERY, 5'h00, 8'h00);
		bang(48'(`IPL_OP_WREN), 8, rx);
		bang({16'h0, `IPL_OP_WRITE_IDENT, 24'h040002}, 32, rx);
		`CHK("busyKeptProtect", 1'b0, busy2)
		setProt(2'b00);
		bang(48'(`IPL_OP_WREN), 8, rx);
		bang({20'h0, `IPL_OP_WRITE_IDENT, 20'h04000}, 28, rx);
		`CHK("busyMidByte", 1'b0, busy2)
		bang(48'(`IPL_OP_WREN), 8, rx);
		bang({16'h0, `IPL_OP_WRITE_IDENT, 24'h040002}, 32, rx);
		`CHK("busy2Lock", 1'b1, busy2)
		waitLvl(2, 1'b0, 1200);
		`CHK("locked2", 1'b1, locked2)
		bang({`IPL_OP_READ_IDENT, 40'h0400000000}, 48, rx);
		`CHK("repeatStatus", 24'h010101, rx[23:0])
		`CHK("released2", 1'b0, spi2.misoOe)
		`CHK("notesLeft", 0, expQ.size())
		wrap_up();
	end
endmodule
